// ---- core/mcu_interrupt_sequencer.sv ----
// interrupt sequencer: flags, enables, acknowledge and return sequences
// assumes the cpu sequencer presents boundaries, opcodes and stack data
`default_nettype none

module mcu_interrupt_sequencer
  import mis_pkg::*;
#(
  parameter int PCW = PC_W,
  parameter int SPW = SP_W
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // pin, timer and cpu sequencer side
  input  wire logic             port_g_bit0,
  input  wire logic             timer_event,
  input  wire logic             instr_boundary,
  input  wire logic             opcode_zero,
  input  wire logic [PCW-1:0]   next_pc,
  input  wire logic [3:0]       return_op,
  input  wire logic [PCW-1:0]   pop_data,
  // software writes of the mapped registers
  input  wire logic             status_wr,
  input  wire logic [ST_W-1:0]  status_wdata,
  input  wire logic             control_wr,
  input  wire logic [CTL_W-1:0] control_wdata,
  input  wire logic             sp_wr,
  input  wire logic [SPW-1:0]   sp_wdata,
  // register views and stack ram side
  output var  logic [ST_W-1:0]  status_flags_reg,
  output var  logic [CTL_W-1:0] control_reg,
  output var  logic [SPW-1:0]   stack_pointer,
  output var  logic [PCW-1:0]   program_counter,
  output var  logic             pc_load,
  output var  logic             push_strobe,
  output var  logic [SPW-1:0]   push_addr,
  output var  logic [PCW-1:0]   push_data,
  output var  logic             pop_strobe,
  output var  logic [SPW-1:0]   pop_addr,
  output var  logic             skip_next,
  output var  logic             seq_busy,
  output var  logic             irq_request
);
  // ------------------------------------------------------------
  // cycle tick and external edge
  // ------------------------------------------------------------
  logic tick;
  logic extHit;

  mis_cycle_tick #(
    .DIV (TC_CLKS)
  ) u_tick (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .tick    (tick)
  );

  mis_edge_catch u_edge (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .tick    (tick),
    .pin     (port_g_bit0),
    .fallSel (control_reg[CTL_EDGE_BIT]),
    .hit     (extHit)
  );

  // ------------------------------------------------------------
  // request decode
  // ------------------------------------------------------------
  mis_state_t      state;
  logic [CYC_W-1:0] cycCount;
  logic            hwReq;
  logic            startHw;
  logic            startSw;
  logic            startPop;
  logic            popRet;
  logic            popRetS;
  logic            popRetI;

  function automatic logic maskable_req(input logic [ST_W-1:0] st);
    maskable_req = st[ST_GIE_BIT] &
                   ((st[ST_EXTP_BIT] & st[ST_ENI_BIT]) |
                    (st[ST_TMRP_BIT] & st[ST_TIMER_IRQ_ENABLE_BIT]));
  endfunction

  assign hwReq    = maskable_req(status_flags_reg);
  // boundary start
  // registered enables let a same-cycle clear still start a sequence
  assign startHw  = tick & instr_boundary & (state == MIS_IDLE) & hwReq;
  assign startSw  = tick & instr_boundary & (state == MIS_IDLE) &
                    ~hwReq & opcode_zero;

  // ------------------------------------------------------------
  // return decode
  // ------------------------------------------------------------
  always_comb begin
    popRet  = 1'b0;
    popRetS = 1'b0;
    popRetI = 1'b0;
    case (return_op)
      MIS_OP_RET: begin
        popRet = 1'b1;
      end
      MIS_OP_RETS: begin
        popRetS = 1'b1;
      end
      MIS_OP_RETURN_ENABLE_IRQ: begin
        popRetI = 1'b1;
      end
      default: begin
        popRet = 1'b0;
      end
    endcase
  end

  assign startPop = tick & instr_boundary & (state == MIS_IDLE) &
                    ~hwReq & ~opcode_zero & (popRet | popRetS | popRetI);

  // ------------------------------------------------------------
  // sequence state
  // ------------------------------------------------------------
  logic retEnable;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state    <= MIS_IDLE;
      cycCount <= 3'h0;
      seq_busy <= 1'b0;
    end else if (tick) begin
      case (state)
        MIS_IDLE: begin
          if (startHw | startSw) begin
            state    <= MIS_ACK;
            cycCount <= 3'(ACK_CYCLES - 1);
            seq_busy <= 1'b1;
          end else if (startPop) begin
            state    <= MIS_POP;
            seq_busy <= 1'b1;
          end
        end
        MIS_ACK: begin
          if (cycCount == 3'h1) begin
            state    <= MIS_IDLE;
            seq_busy <= 1'b0;
          end
          cycCount <= cycCount - 3'h1;
        end
        MIS_POP: begin
          state    <= MIS_IDLE;
          seq_busy <= 1'b0;
        end
        default: begin
          state    <= MIS_IDLE;
          seq_busy <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      retEnable <= 1'b0;
      skip_next <= 1'b0;
    end else if (tick) begin
      if (startPop) begin
        retEnable <= popRetI;
        skip_next <= popRetS;
      end else begin
        skip_next <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // stack pointer and stack ram strobes
  // ------------------------------------------------------------
  // push, pop and pointer step
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stack_pointer <= SP_RESET;
      push_strobe   <= 1'b0;
      push_addr     <= 8'h00;
      push_data     <= PC_RESET;
      pop_strobe    <= 1'b0;
      pop_addr      <= 8'h00;
    end else begin
      push_strobe <= 1'b0;
      pop_strobe  <= 1'b0;
      if (tick & (startHw | startSw)) begin
        push_strobe   <= 1'b1;
        push_addr     <= stack_pointer;
        push_data     <= next_pc;
        stack_pointer <= stack_pointer - SP_STEP;
      end else if (tick & startPop) begin
        pop_strobe    <= 1'b1;
        pop_addr      <= stack_pointer + SP_STEP;
        stack_pointer <= stack_pointer + SP_STEP;
      end else if (sp_wr) begin
        stack_pointer <= sp_wdata;
      end
    end
  end

  // ------------------------------------------------------------
  // program counter
  // ------------------------------------------------------------
  // vector and return address load
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      program_counter <= PC_RESET;
      pc_load         <= 1'b0;
    end else begin
      pc_load <= 1'b0;
      if (tick & (state == MIS_ACK) & (cycCount == 3'h1)) begin
        program_counter <= IRQ_VECTOR;
        pc_load         <= 1'b1;
      end else if (tick & (state == MIS_POP)) begin
        program_counter <= pop_data;
        pc_load         <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // status and control registers
  // ------------------------------------------------------------
  logic [ST_W-1:0] next_status;

  always_comb begin
    next_status = status_wr ? status_wdata : status_flags_reg;
    if (tick & startHw) begin
      next_status[ST_GIE_BIT] = 1'b0;
    end
    if (tick & (state == MIS_POP) & retEnable) begin
      next_status[ST_GIE_BIT] = 1'b1;
    end
    if (extHit) begin
      next_status[ST_EXTP_BIT] = 1'b1;
    end
    if (timer_event) begin
      next_status[ST_TMRP_BIT] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      status_flags_reg <= REG_RESET;
    end else begin
      status_flags_reg <= next_status;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      control_reg <= REG_RESET;
    end else if (control_wr) begin
      control_reg <= control_wdata;
    end
  end

  // ------------------------------------------------------------
  // request output
  // ------------------------------------------------------------
  // registered request
  // built from the next status so it lines up with the register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_request <= 1'b0;
    end else begin
      irq_request <= maskable_req(next_status);
    end
  end
endmodule

`default_nettype wire

// ---- core/mis_cycle_tick.sv ----
// instruction-cycle enable divider
// assumes the system clock and synchronous reset of the block
`default_nettype none

module mis_cycle_tick
  import mis_pkg::*;
#(
  parameter int DIV = TC_CLKS
) (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  output var  logic tick
);
  logic [6:0] count;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      count <= 7'h00;
      tick  <= 1'b0;
    end else if (count == 7'(DIV - 1)) begin
      count <= 7'h00;
      tick  <= 1'b1;
    end else begin
      count <= count + 7'h01;
      tick  <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// ---- core/mis_edge_catch.sv ----
// pin sampler with selectable edge detection on cycle ticks
// assumes the pin is synchronous to sys_clk
`default_nettype none

module mis_edge_catch (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic tick,
  input  wire logic pin,
  input  wire logic fallSel,
  output var  logic hit
);
  logic prevPin;
  logic armed;

  // first tick only loads the sample, so no false edge follows reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prevPin <= 1'b0;
      armed   <= 1'b0;
      hit     <= 1'b0;
    end else if (tick) begin
      prevPin <= pin;
      armed   <= 1'b1;
      hit     <= armed & (fallSel ? (prevPin & ~pin) : (~prevPin & pin));
    end else begin
      hit     <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// ---- core/mis_pkg.sv ----
// constants shared by the interrupt sequencer files
// assumes one 50 MHz clock and synchronous active-high reset
`default_nettype none

package mis_pkg;
  localparam int          PC_W          = 15;
  localparam int          SP_W          = 8;
  localparam int          CYC_W         = 3;
  // instruction cycle time in ns and the clock period in ns
  localparam int          TC_NS         = 1000;
  localparam int          CLK_NS        = 20;
  localparam int          TC_CLKS       = TC_NS / CLK_NS;
  localparam int          ACK_CYCLES    = 7;
  localparam logic [14:0] IRQ_VECTOR    = 15'h00FF;
  localparam logic [14:0] PC_RESET      = 15'h0000;
  localparam logic [7:0]  SP_RESET      = 8'h6F;
  localparam logic [7:0]  SP_STEP       = 8'h02;
  // control register bit positions
  localparam int          CTL_EDGE_BIT  = 1;
  localparam int          CTL_W         = 8;
  // status register bit positions
  localparam int          ST_GIE_BIT    = 0;
  localparam int          ST_ENI_BIT    = 1;
  localparam int          ST_EXTP_BIT   = 3;
  localparam int          ST_TIMER_IRQ_ENABLE_BIT   = 4;
  localparam int          ST_TMRP_BIT   = 5;
  localparam int          ST_W          = 8;
  localparam logic [7:0]  REG_RESET     = 8'h00;

  typedef enum logic [3:0] {
    MIS_OP_NONE = 4'h1,
    MIS_OP_RET  = 4'h2,
    MIS_OP_RETS = 4'h4,
    MIS_OP_RETURN_ENABLE_IRQ = 4'h8
  } mis_ret_t;

  typedef enum logic [2:0] {
    MIS_IDLE = 3'h1,
    MIS_ACK  = 3'h2,
    MIS_POP  = 3'h4
  } mis_state_t;
endpackage

`default_nettype wire

// ---- verif/mcu_interrupt_sequencer_bench.sv ----
// randomised self-checking bench for the interrupt sequencer
// assumes the stack ram model and the bound checker
`default_nettype none
module mcu_interrupt_sequencer_bench
  import mis_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 0, sys_rst = 1, port_g_bit0 = 0;
  logic        timer_event = 0, instr_boundary = 0, opcode_zero = 0;
  logic        status_wr = 0, control_wr = 0, sp_wr = 0;
  logic        pc_load, push_strobe, pop_strobe, skip_next, seq_busy;
  logic        irq_request;
  logic        skipSeen = 0;
  logic [3:0]  return_op = MIS_OP_NONE;
  logic [14:0] next_pc = 0, pop_data, program_counter, push_data, savedPc;
  logic [7:0]  status_wdata = 0, control_wdata = 0, sp_wdata = 0;
  logic [7:0]  status_flags_reg, control_reg, stack_pointer;
  logic [7:0]  push_addr, pop_addr;
  int          fail_count = 0, n_tests = 0;

  always #10 sys_clk = ~sys_clk;

  mcu_interrupt_sequencer dut_u (
    .sys_clk, .sys_rst, .port_g_bit0, .timer_event, .instr_boundary,
    .opcode_zero, .next_pc, .return_op, .pop_data, .status_wr,
    .status_wdata, .control_wr, .control_wdata, .sp_wr, .sp_wdata,
    .status_flags_reg, .control_reg, .stack_pointer, .program_counter,
    .pc_load, .push_strobe, .push_addr, .push_data, .pop_strobe,
    .pop_addr, .skip_next, .seq_busy, .irq_request
  );
  mis_stack_ram ram_u (
    .sys_clk, .push_strobe, .push_addr, .push_data, .pop_strobe,
    .pop_addr, .pop_data
  );

  // -------
  // helpers
  // -------
  function automatic logic [7:0] st(input logic g, ei, ep, ti, tp);
    st = REG_RESET;
    st[ST_GIE_BIT] = g;
    st[ST_ENI_BIT] = ei;
    st[ST_EXTP_BIT] = ep;
    st[ST_TIMER_IRQ_ENABLE_BIT] = ti;
    st[ST_TMRP_BIT] = tp;
  endfunction
  task automatic chk(input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compares=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    for (int i = 0; i < lim && s !== 1'b1; i++)
      step(1);
    if (s !== 1'b1) begin
      fail_count++;
      give_verdict();
    end
  endtask
  // enable clears kept away from boundaries
  task automatic wr_st(input logic [7:0] v);
    status_wdata = v;
    status_wr = 1;
    step(1);
    status_wr = 0;
    step(3);
  endtask
  task automatic pulse_timer;
    timer_event = 1;
    step(1);
    timer_event = 0;
    step(3);
  endtask
  // boundary held until the sequence starts, then wait for the load
  task automatic issue(input logic oz, input logic [3:0] rop);
    step(60);
    next_pc = 15'($urandom);
    opcode_zero = oz;
    return_op = rop;
    instr_boundary = 1;
    wait_hi(seq_busy, 200);
    skipSeen = skip_next;
    instr_boundary = 0;
    opcode_zero = 0;
    return_op = MIS_OP_NONE;
    wait_hi(pc_load, 400);
  endtask

  // ---------
  // sequence
  // ---------
  initial begin
    void'($urandom(55366));
    step(6);
    sys_rst = 0;
    step(1);
    chk(status_flags_reg, REG_RESET);
    chk(control_reg, REG_RESET);
    chk(stack_pointer, SP_RESET);
    chk(program_counter, PC_RESET);
    pulse_timer();
    chk(status_flags_reg, st(0, 0, 0, 0, 1));
    wr_st(st(1, 0, 0, 1, 1));
    chk(irq_request, 1);
    wr_st(REG_RESET);
    $display("timer test done");
    for (int k = 0; k < 2; k++) begin
      control_wdata = 8'(k << CTL_EDGE_BIT);
      control_wr = 1;
      port_g_bit0 = !k[0];
      step(1);
      control_wr = 0;
      step(60 + $urandom_range(60));
      wr_st(REG_RESET);
      port_g_bit0 = k[0];
      step(120);
      chk(status_flags_reg, REG_RESET);
      port_g_bit0 = !k[0];
      step(120);
      chk(status_flags_reg, st(0, 0, 1, 0, 0));
      wr_st(st(1, 1, 1, 0, 0));
      chk(irq_request, 1);
      issue(0, MIS_OP_NONE);
      savedPc = push_data;
      chk(push_data, next_pc);
      chk(stack_pointer, SP_RESET - SP_STEP);
      chk(status_flags_reg, st(0, 1, 1, 0, 0));
      chk(program_counter, IRQ_VECTOR);
      wr_st(st(0, 1, 0, 0, 0));
      issue(0, k ? MIS_OP_RET : MIS_OP_RETURN_ENABLE_IRQ);
      chk(program_counter, savedPc);
      chk(stack_pointer, SP_RESET);
      chk(status_flags_reg, st(!k[0], 1, 0, 0, 0));
      $display("edge test %0d done", k);
    end
    wr_st(st(1, 0, 0, 1, 0));
    issue(1, MIS_OP_NONE);
    savedPc = push_data;
    chk(status_flags_reg, st(1, 0, 0, 1, 0));
    pulse_timer();
    chk(irq_request, 1);
    issue(0, MIS_OP_NONE);
    chk(stack_pointer, SP_RESET - 2 * SP_STEP);
    chk(status_flags_reg, st(0, 0, 0, 1, 1));
    wr_st(st(1, 0, 0, 1, 0));
    pulse_timer();
    chk(irq_request, 1);
    wr_st(st(0, 0, 0, 1, 0));
    issue(0, MIS_OP_RETURN_ENABLE_IRQ);
    chk(skipSeen, 0);
    // skip return ends the software routine
    issue(0, MIS_OP_RETS);
    chk(skipSeen, 1);
    chk(stack_pointer, SP_RESET);
    chk(program_counter, savedPc);
    chk(status_flags_reg, st(1, 0, 0, 1, 0));
    $display("software test done");
    give_verdict();
  end
endmodule
`default_nettype wire

// ---- verif/mis_assertions.sv ----
// checker on the sequencer top ports
// assumes a bind into mcu_interrupt_sequencer
`default_nettype none
module mis_checker
  import mis_pkg::*;
#(
  parameter int PCW = PC_W,
  parameter int SPW = SP_W
) (
  input wire logic             sys_clk,
  input wire logic             sys_rst,
  input wire logic             timer_event,
  input wire logic             status_wr,
  input wire logic [ST_W-1:0]  status_flags_reg,
  input wire logic [CTL_W-1:0] control_reg,
  input wire logic [SPW-1:0]   stack_pointer,
  input wire logic [PCW-1:0]   program_counter,
  input wire logic [PCW-1:0]   pop_data,
  input wire logic             pc_load,
  input wire logic             push_strobe,
  input wire logic             pop_strobe,
  input wire logic             seq_busy,
  input wire logic             irq_request
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [ST_W-1:0] s;
  logic            req;
  assign s = status_flags_reg;
  assign req = s[ST_GIE_BIT] && (s[ST_ENI_BIT] && s[ST_EXTP_BIT]
               || s[ST_TIMER_IRQ_ENABLE_BIT] && s[ST_TMRP_BIT]);
  sequence s_hold;
    (seq_busy && !pc_load)[*8];
  endsequence
  sequence s_vec;
    pc_load && program_counter == IRQ_VECTOR;
  endsequence
  property p_push_sp;
    push_strobe |-> stack_pointer == $past(stack_pointer) - SP_STEP;
  endproperty
  property p_vector;
    push_strobe |=> s_hold ##[280:310] s_vec;
  endproperty
  property p_gie_clr;
    push_strobe && $past(irq_request) |-> !s[ST_GIE_BIT];
  endproperty
  property p_pop_sp;
    pop_strobe |-> stack_pointer == $past(stack_pointer) + SP_STEP;
  endproperty
  property p_pop_pc;
    pop_strobe |-> ##[40:60] (pc_load && program_counter == pop_data);
  endproperty
  property p_pend;
    $fell(s[ST_EXTP_BIT]) || $fell(s[ST_TMRP_BIT]) |-> $past(status_wr);
  endproperty
  property p_tmr;
    timer_event |=> s[ST_TMRP_BIT];
  endproperty
  property p_req;
    irq_request == req;
  endproperty
  property p_sw_gie;
    push_strobe && !$past(irq_request) && !$past(status_wr) |->
      s[ST_GIE_BIT] == $past(s[ST_GIE_BIT]);
  endproperty
  property p_rst;
    disable iff (1'b0) sys_rst |=> s == REG_RESET && control_reg ==
      REG_RESET && program_counter == PC_RESET;
  endproperty
  a_push_sp: assert property (p_push_sp) else $error("push sp");
  a_vector: assert property (p_vector) else $error("vector");
  a_gie_clr: assert property (p_gie_clr) else $error("gie");
  a_pop_sp: assert property (p_pop_sp) else $error("pop sp");
  a_pop_pc: assert property (p_pop_pc) else $error("pop pc");
  a_pend: assert property (p_pend) else $error("pending");
  a_tmr: assert property (p_tmr) else $error("timer flag");
  a_req: assert property (p_req) else $error("request");
  a_sw_gie: assert property (p_sw_gie) else $error("sw gie");
  a_rst: assert property (p_rst) else $error("reset");
endmodule

bind mcu_interrupt_sequencer mis_checker #(.PCW(PCW), .SPW(SPW)) chk_u (
  .sys_clk, .sys_rst, .timer_event, .status_wr, .status_flags_reg,
  .control_reg, .stack_pointer, .program_counter, .pop_data, .pc_load,
  .push_strobe, .pop_strobe, .seq_busy, .irq_request
);
`default_nettype wire

// ---- verif/mis_stack_ram.sv ----
// stack ram model on the push and pop strobes
// assumes address and data valid while a strobe is high
`default_nettype none
module mis_stack_ram (
  input  wire logic        sys_clk,
  input  wire logic        push_strobe,
  input  wire logic [7:0]  push_addr,
  input  wire logic [14:0] push_data,
  input  wire logic        pop_strobe,
  input  wire logic [7:0]  pop_addr,
  output var  logic [14:0] pop_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [14:0] mem [256];
  initial pop_data = 15'h5555;
  always @(posedge sys_clk) begin
    if (push_strobe)
      mem[push_addr] <= push_data;
    if (pop_strobe)
      pop_data <= mem[pop_addr];
  end
endmodule
`default_nettype wire
